/* File: hw/hp_det_defs.svh */
`ifndef HP_DET_DEFS_SVH
`define HP_DET_DEFS_SVH

// controller register byte offsets (APB slave side)
`define CTL_OFF 12'h000
`define HPCFG_OFF 12'h004
`define MICCFG_OFF 12'h008
`define STAT_OFF 12'h00C
`define RES_OFF 12'h010

// controller register reset values
`define CTL_RST 32'h0000_0000
`define HPCFG_RST 32'h0000_0000
`define MICCFG_RST 32'h009F_0000

// device register indexes; byte address is four times the index
`define DEV_BIAS_IDX 16'h0200
`define DEV_MICCTL_IDX 16'h02B3
`define DEV_LVLSEL_IDX 16'h02B4
`define DEV_LVL_IDX 16'h02B5
`define DEV_HPD0_IDX 16'h0299
`define DEV_HPD1_IDX 16'h029A
`define DEV_HPSTS_IDX 16'h029B
`define DEV_DRV_IDX 16'h0300

// device field positions
`define HPD0_OVD_BIT 15
`define HPD0_CHAN_LSB 12
`define HPD0_FRC_LSB 0
`define HPD1_POLL_BIT 0
`define HPD1_RANGE_LSB 1
`define HPD1_DIV_LSB 3
`define HPD1_RATE_LSB 5
`define HPD1_SENSE_LSB 8
`define HPD1_GND_LSB 12
`define HPSTS_DONE_BIT 15
`define LVL_LSB 2
`define BIAS_GEN1_BIT 0
`define BIAS_GEN2_BIT 1
`define MICCTL_SETTLE_LSB 4
`define MICCTL_RATE_LSB 8
`define MICCTL_MODE_BIT 12

// pin codes and limits
`define PIN_JACK1 4'h2
`define PIN_HPDET_LAST 4'h1
`define CODE_MIN 10'h0A9
`define RANGE_TOP 2'h3
`define SETTLE_MIN 4'h4
`define STEP_LAST 3'h6
`define STEP_HPD1 3'h5
`define DRV_ONE 6'h01

`endif

/* File: hw/hp_det_pkg.sv */
package hp_det_pkg;

    typedef struct packed {
        logic [31:0] paddr;
        logic pwrite;
        logic [31:0] pwdata;
        logic psel;
        logic penable;
    } apb_out_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_in_t;

    typedef struct packed {
        logic [3:0] sense_sel;
        logic [3:0] return_sel;
        logic [3:0] current_sel;
        logic [1:0] range_sel;
        logic override_en;
        logic [2:0] channel_sel;
        logic [1:0] sweep_div;
        logic [1:0] sweep_rate;
    } hp_cfg_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WRITE = 3'b001,
        ST_POLL = 3'b011,
        ST_LEVEL = 3'b010,
        ST_CHECK = 3'b110
    } seq_state_t;

endpackage : hp_det_pkg

/* File: hw/apb_master_port.sv */
`timescale 1ns/1ps
module apb_master_port
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req,
    input wire logic req_write,
    input wire logic [31:0] req_addr,
    input wire logic [31:0] req_wdata,
    output logic done,
    output logic [31:0] rdata,
    output hp_det_pkg::apb_out_t bus_out,
    input wire hp_det_pkg::apb_in_t bus_in
);

    hp_det_pkg::apb_out_t out_reg, out_next;
    logic [31:0] rdata_reg, rdata_next;
    logic finish;

    assign finish = out_reg.psel && out_reg.penable && bus_in.pready;
    assign done = finish;
    assign rdata = rdata_reg;
    assign bus_out = out_reg;

    always_comb
    begin
        out_next = out_reg;
        rdata_next = rdata_reg;
        if (!out_reg.psel && req)
        begin
            out_next.psel = 1'b1;
            out_next.penable = 1'b0;
            out_next.pwrite = req_write;
            out_next.paddr = req_addr;
            out_next.pwdata = req_wdata;
        end
        else if (out_reg.psel && !out_reg.penable)
        begin
            out_next.penable = 1'b1;
        end
        else if (finish)
        begin
            // request held until this edge, then released
            out_next.psel = 1'b0;
            out_next.penable = 1'b0;
            if (!out_reg.pwrite)
            begin
                rdata_next = bus_in.prdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_reg <= '0;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            out_reg <= out_next;
            rdata_reg <= rdata_next;
        end
    end

endmodule : apb_master_port

/* File: hw/hp_det_host.sv */
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "hp_det_defs.svh"

// Summary of operation
// - settle delay at least 0.25 ms if interval nonzero
// - host enables bias generators itself; here they are written from miccfg bits 24 and 25, both clear at reset
// - keep bias discharge cleared when not continuous
// - current pin normally equals sense pin
// - measurement starts on writing poll bit one
// - host sets range select for expected load
// - override on and driver off before measuring
// - hold override config until measurement done
// - clear override when pin not on output
// - shared bias output disabled and floating
// - code valid 169..1019, lower retries next range; host auto-steps hp pins only
module hp_det_host
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output hp_det_pkg::apb_out_t dev_out,
    input wire hp_det_pkg::apb_in_t dev_in
);

    ////////////////////////////////////////////////////////////////////////
    // software registers

    logic [31:0] ctl_reg, ctl_next;
    logic [31:0] hpcfg_reg, hpcfg_next;
    logic [31:0] miccfg_reg, miccfg_next;
    logic pending_reg, pending_next;
    logic done_reg, done_next;
    logic err_reg, err_next;
    logic busy_reg, busy_next;
    logic [9:0] code_reg, code_next;
    logic [8:0] level_reg, level_next;
    logic [1:0] range_reg, range_next;
    logic [2:0] step_reg, step_next;
    hp_det_pkg::hp_cfg_t snap_reg, snap_next;
    hp_det_pkg::seq_state_t state_reg, state_next;

    logic wr_en;
    logic rd_hit;
    logic [11:0] off;
    logic start_wr;
    logic done_clr;
    logic finish_evt;
    logic m_req;
    logic m_write;
    logic [31:0] m_addr;
    logic [31:0] m_wdata;
    logic m_done;
    logic [3:0] settle;
    logic [5:0] drv_mask;
    logic retry;
    logic sense_ok;

    assign off = paddr[11:0];
    assign wr_en = psel && penable && pwrite;
    assign pready = 1'b1;
    assign start_wr = wr_en && off == `CTL_OFF && pwdata[0];
    assign done_clr = wr_en && off == `STAT_OFF && pwdata[1];

    always_comb
    begin
        rd_hit = 1'b1;
        prdata = 32'h0000_0000;
        unique case (off)
            `CTL_OFF: prdata = {ctl_reg[31:1], 1'b0};
            `HPCFG_OFF: prdata = hpcfg_reg;
            `MICCFG_OFF: prdata = miccfg_reg;
            `STAT_OFF: prdata = {26'h0, range_reg, err_reg, pending_reg,
                done_reg, busy_reg};
            `RES_OFF: prdata = {7'h0, level_reg, 6'h0, code_reg};
            default: rd_hit = 1'b0;
        endcase
        if (!psel || pwrite)
        begin
            prdata = 32'h0000_0000;
        end
    end

    assign pslverr = psel && penable && !rd_hit;

    ////////////////////////////////////////////////////////////////////////
    // device access sequence

    // a sense pin wired to an output must be an hp detect or jack1 pin
    assign sense_ok = !hpcfg_reg[14] ||
        hpcfg_reg[3:0] <= `PIN_JACK1;

    // settle delay forced up when the detector runs periodically
    always_comb
    begin
        settle = miccfg_reg[7:4];
        if (miccfg_reg[11:8] != 4'h0 && settle < `SETTLE_MIN)
        begin
            settle = `SETTLE_MIN;
        end
    end

    // driver of the overridden channel is forced off
    always_comb
    begin
        drv_mask = ctl_reg[13:8];
        if (snap_reg.override_en)
        begin
            drv_mask = drv_mask & ~(`DRV_ONE << snap_reg.channel_sel);
        end
    end

    always_comb
    begin
        m_req = state_reg == hp_det_pkg::ST_WRITE ||
            state_reg == hp_det_pkg::ST_POLL ||
            state_reg == hp_det_pkg::ST_LEVEL;
        m_write = state_reg == hp_det_pkg::ST_WRITE;
        m_addr = 32'h0000_0000;
        m_wdata = 32'h0000_0000;
        if (state_reg == hp_det_pkg::ST_POLL)
        begin
            m_addr = {14'h0, `DEV_HPSTS_IDX, 2'b00};
        end
        else if (state_reg == hp_det_pkg::ST_LEVEL)
        begin
            m_addr = {14'h0, `DEV_LVL_IDX, 2'b00};
        end
        else
        begin
            unique case (step_reg)
                3'h0:
                begin
                    // generators set from miccfg bits 24 and 25, bias outputs off and not discharged
                    m_addr = {14'h0, `DEV_BIAS_IDX, 2'b00};
                    m_wdata[`BIAS_GEN1_BIT] = miccfg_reg[24];
                    m_wdata[`BIAS_GEN2_BIT] = miccfg_reg[25];
                end
                3'h1:
                begin
                    m_addr = {14'h0, `DEV_MICCTL_IDX, 2'b00};
                    m_wdata[3:0] = miccfg_reg[3:0];
                    m_wdata[`MICCTL_SETTLE_LSB +: 4] = settle;
                    m_wdata[`MICCTL_RATE_LSB +: 4] = miccfg_reg[11:8];
                    m_wdata[`MICCTL_MODE_BIT] = miccfg_reg[12];
                end
                3'h2:
                begin
                    m_addr = {14'h0, `DEV_LVLSEL_IDX, 2'b00};
                    m_wdata[7:0] = miccfg_reg[23:16];
                end
                3'h3:
                begin
                    m_addr = {14'h0, `DEV_DRV_IDX, 2'b00};
                    m_wdata[5:0] = drv_mask;
                end
                3'h4:
                begin
                    m_addr = {14'h0, `DEV_HPD0_IDX, 2'b00};
                    m_wdata[`HPD0_OVD_BIT] = snap_reg.override_en;
                    m_wdata[`HPD0_CHAN_LSB +: 3] = snap_reg.channel_sel;
                    m_wdata[`HPD0_FRC_LSB +: 4] = snap_reg.current_sel;
                end
                default:
                begin
                    m_addr = {14'h0, `DEV_HPD1_IDX, 2'b00};
                    m_wdata[`HPD1_SENSE_LSB +: 4] = snap_reg.sense_sel;
                    m_wdata[`HPD1_GND_LSB +: 4] = snap_reg.return_sel;
                    m_wdata[`HPD1_RANGE_LSB +: 2] = range_reg;
                    m_wdata[`HPD1_DIV_LSB +: 2] = snap_reg.sweep_div;
                    m_wdata[`HPD1_RATE_LSB +: 2] = snap_reg.sweep_rate;
                    m_wdata[`HPD1_POLL_BIT] = step_reg == `STEP_LAST;
                end
            endcase
        end
    end

    apb_master_port u_master
    (
        .pclk(pclk),
        .presetn(presetn),
        .req(m_req),
        .req_write(m_write),
        .req_addr(m_addr),
        .req_wdata(m_wdata),
        .done(m_done),
        .rdata(),
        .bus_out(dev_out),
        .bus_in(dev_in)
    );

    // low code means impedance above this range; only hp pins auto-step
    assign retry = ctl_reg[1] && code_reg < `CODE_MIN &&
        range_reg != `RANGE_TOP &&
        snap_reg.sense_sel <= `PIN_HPDET_LAST;
    assign finish_evt = state_reg == hp_det_pkg::ST_CHECK && !retry;

    always_comb
    begin
        ctl_next = ctl_reg;
        hpcfg_next = hpcfg_reg;
        miccfg_next = miccfg_reg;
        state_next = state_reg;
        step_next = step_reg;
        snap_next = snap_reg;
        range_next = range_reg;
        busy_next = busy_reg;
        code_next = code_reg;
        level_next = level_reg;
        err_next = err_reg;
        pending_next = pending_reg;
        done_next = done_reg;
        if (wr_en && off == `CTL_OFF)
        begin
            ctl_next = {pwdata[31:1], 1'b0};
        end
        // hp config is snapshotted at start, so its edits mid-run stay harmless
        if (wr_en && off == `HPCFG_OFF)
        begin
            hpcfg_next = pwdata;
        end
        if (wr_en && off == `MICCFG_OFF)
        begin
            miccfg_next = pwdata;
        end
        if (wr_en && off == `STAT_OFF && pwdata[3])
        begin
            err_next = 1'b0;
        end
        if (done_clr)
        begin
            done_next = 1'b0;
        end
        unique case (state_reg)
            hp_det_pkg::ST_IDLE:
            begin
                if (pending_reg)
                begin
                    pending_next = 1'b0;
                    if (!sense_ok)
                    begin
                        err_next = 1'b1;
                    end
                    else
                    begin
                        snap_next = {hpcfg_reg[3:0], hpcfg_reg[7:4],
                            hpcfg_reg[11:8], hpcfg_reg[13:12], hpcfg_reg[14],
                            hpcfg_reg[18:16], hpcfg_reg[21:20],
                            hpcfg_reg[23:22]};
                        range_next = hpcfg_reg[13:12];
                        step_next = 3'h0;
                        busy_next = 1'b1;
                        state_next = hp_det_pkg::ST_WRITE;
                    end
                end
            end
            hp_det_pkg::ST_WRITE:
            begin
                if (m_done)
                begin
                    if (step_reg == `STEP_LAST)
                    begin
                        state_next = hp_det_pkg::ST_POLL;
                    end
                    else
                    begin
                        step_next = step_reg + 3'h1;
                    end
                end
            end
            hp_det_pkg::ST_POLL:
            begin
                if (m_done && dev_in.prdata[`HPSTS_DONE_BIT])
                begin
                    code_next = dev_in.prdata[9:0];
                    state_next = hp_det_pkg::ST_LEVEL;
                end
            end
            hp_det_pkg::ST_LEVEL:
            begin
                if (m_done)
                begin
                    level_next = dev_in.prdata[`LVL_LSB +: 9];
                    state_next = hp_det_pkg::ST_CHECK;
                end
            end
            hp_det_pkg::ST_CHECK:
            begin
                if (retry)
                begin
                    range_next = range_reg + 2'h1;
                    step_next = `STEP_HPD1;
                    state_next = hp_det_pkg::ST_WRITE;
                end
                else
                begin
                    busy_next = 1'b0;
                    state_next = hp_det_pkg::ST_IDLE;
                end
            end
            default:
            begin
                state_next = hp_det_pkg::ST_IDLE;
            end
        endcase
        // a new event beats a clear in the same cycle
        if (start_wr)
        begin
            pending_next = 1'b1;
        end
        if (finish_evt)
        begin
            done_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl_reg <= `CTL_RST;
            hpcfg_reg <= `HPCFG_RST;
            miccfg_reg <= `MICCFG_RST;
            state_reg <= hp_det_pkg::ST_IDLE;
            step_reg <= 3'h0;
            snap_reg <= '0;
            range_reg <= 2'h0;
            busy_reg <= 1'b0;
            code_reg <= 10'h000;
            level_reg <= 9'h000;
            err_reg <= 1'b0;
            pending_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            ctl_reg <= ctl_next;
            hpcfg_reg <= hpcfg_next;
            miccfg_reg <= miccfg_next;
            state_reg <= state_next;
            step_reg <= step_next;
            snap_reg <= snap_next;
            range_reg <= range_next;
            busy_reg <= busy_next;
            code_reg <= code_next;
            level_reg <= level_next;
            err_reg <= err_next;
            pending_reg <= pending_next;
            done_reg <= done_next;
        end
    end

endmodule : hp_det_host

/* File: dv/hp_det_host_properties.sv */
`timescale 1ns/1ps
`include "hp_det_defs.svh"
module hp_det_host_properties
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire hp_det_pkg::apb_out_t dev_out,
    input wire hp_det_pkg::apb_in_t dev_in
);
    localparam logic [31:0] A_BIAS = {14'h0, `DEV_BIAS_IDX, 2'b00};
    localparam logic [31:0] A_MIC = {14'h0, `DEV_MICCTL_IDX, 2'b00};
    localparam logic [31:0] A_HPD0 = {14'h0, `DEV_HPD0_IDX, 2'b00};
    localparam logic [31:0] A_HPD1 = {14'h0, `DEV_HPD1_IDX, 2'b00};
    localparam logic [31:0] A_DRV = {14'h0, `DEV_DRV_IDX, 2'b00};
    logic dv_done;
    logic dv_wr;
    assign dv_done = dev_out.psel && dev_out.penable && dev_in.pready;
    assign dv_wr = dv_done && dev_out.pwrite;

    // override state last sent to the device
    logic ovd_seen;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ovd_seen <= 1'b0;
        end
        else if (dv_wr && dev_out.paddr == A_HPD0)
        begin
            ovd_seen <= dev_out.pwdata[15];
        end
    end

    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////
    chk_wired_sense: assert property (
        dv_wr && dev_out.paddr == A_HPD1 && ovd_seen
        |-> dev_out.pwdata[11:8] <= `PIN_JACK1)
        else $error("wired sense pin outside allowed set");
    chk_unmapped_err: assert property (psel && penable
        && paddr[11:0] > `RES_OFF |-> pslverr && prdata == '0)
        else $error("unmapped access not refused");
    chk_start_reads: assert property (
        psel && penable && !pwrite && paddr[11:0] == `CTL_OFF |-> !prdata[0])
        else $error("start bit readable");
    chk_dev_setup: assert property (dev_out.psel && !dev_out.penable
        |=> dev_out.psel && dev_out.penable && $stable(dev_out.paddr)
        && $stable(dev_out.pwrite) && $stable(dev_out.pwdata))
        else $error("device setup not followed by access");
    chk_dev_hold: assert property (dev_out.psel && dev_out.penable
        && !dev_in.pready |=> dev_out.penable && $stable(dev_out.paddr)
        && $stable(dev_out.pwdata))
        else $error("device request dropped early");
    chk_dev_gap: assert property (dv_done |=> !dev_out.psel
        && !dev_out.penable)
        else $error("no idle cycle after device transfer");
    chk_settle_clamp: assert property (
        dv_wr && dev_out.paddr == A_MIC && dev_out.pwdata[11:8] != 4'h0
        |-> dev_out.pwdata[7:4] >= `SETTLE_MIN)
        else $error("settle delay too short");
    chk_bias_float: assert property (
        dv_wr && dev_out.paddr == A_BIAS |-> dev_out.pwdata[31:2] == '0)
        else $error("bias output or discharge driven");
    chk_poll_pair: assert property (
        dv_wr && dev_out.paddr == A_HPD1 && !dev_out.pwdata[0]
        |-> ##2 dev_out.psel && !dev_out.penable && dev_out.pwrite
        && dev_out.paddr == A_HPD1 && dev_out.pwdata[0])
        else $error("trigger write does not follow setup");
    chk_drv_first: assert property (
        dv_wr && dev_out.paddr == A_DRV
        |-> ##2 dev_out.psel && dev_out.paddr == A_HPD0)
        else $error("override not written after driver");
endmodule : hp_det_host_properties

bind hp_det_host hp_det_host_properties chk
(
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .dev_out(dev_out),
    .dev_in(dev_in)
);

/* File: dv/hp_dev_model.sv */
`timescale 1ns/1ps
`include "hp_det_defs.svh"
module hp_dev_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire hp_det_pkg::apb_out_t bus_out,
    output hp_det_pkg::apb_in_t bus_in,
    input wire logic [3:0] wait_n,
    input wire logic [1:0] good_range,
    input wire logic [3:0] true_level
);
    logic [31:0] mem [0:1023];
    logic [3:0] wcnt;
    logic [1:0] rng;
    logic [9:0] idx;
    int polls;
    int meas;
    assign idx = bus_out.paddr[11:2];

    // a disabled level falls to the next enabled one below it
    function automatic logic [8:0] report(input logic [3:0] lv,
        input logic [7:0] m);
        int j;
        j = lv;
        while (j > 0 && !m[j-1])
            j--;
        return 9'h001 << j;
    endfunction : report

    ////////////////////////////////////////////////////////////////////////
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 1024; i++)
                mem[i] <= '0;
            bus_in <= '0;
            wcnt <= '0;
            rng <= '0;
            polls <= 0;
            meas <= 0;
        end
        else
        begin
            bus_in.pready <= 1'b0;
            // a released bus never keeps showing the last word
            bus_in.prdata <= ~bus_in.prdata;
            if (meas == 1)
            begin
                mem[`DEV_HPSTS_IDX] <= {16'h0, 1'b1, 5'h0,
                    (rng >= good_range) ? 10'h1F4 : 10'h064};
                mem[`DEV_LVL_IDX] <= {21'h0, report(true_level,
                    mem[`DEV_LVLSEL_IDX][7:0]), 2'b00};
            end
            if (meas > 0)
                meas <= meas - 1;
            if (bus_out.psel && bus_out.penable && !bus_in.pready)
            begin
                wcnt <= wcnt + 4'h1;
                if (wcnt >= wait_n)
                begin
                    wcnt <= '0;
                    bus_in.pready <= 1'b1;
                    bus_in.prdata <= mem[idx];
                    if (bus_out.pwrite)
                        mem[idx] <= bus_out.pwdata;
                    if (bus_out.pwrite && idx == `DEV_HPD1_IDX
                        && bus_out.pwdata[0])
                    begin
                        polls <= polls + 1;
                        rng <= bus_out.pwdata[2:1];
                        // bias settle, then a sweep paced by div and rate
                        meas <= 8 + 4 * bus_out.pwdata[6:3]
                            + mem[`DEV_MICCTL_IDX][7:4];
                        mem[`DEV_HPSTS_IDX] <= '0;
                    end
                end
            end
        end
    end
endmodule : hp_dev_model

/* File: dv/test_hp_det_host.sv */
`timescale 1ns/1ps
`include "hp_det_defs.svh"
module test_hp_det_host;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    hp_det_pkg::apb_out_t dev_out;
    hp_det_pkg::apb_in_t dev_in;
    logic [3:0] wait_n = 4'h3;
    logic [1:0] good_range = 2'h1;
    logic [3:0] true_level = 4'h3;
    int mismatches = 0;
    int total_checks = 0;
    logic [31:0] d;
    logic e;

    always #20 pclk = ~pclk;

    hp_det_host uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dev_out(dev_out), .dev_in(dev_in));
    hp_dev_model dev (.pclk(pclk), .presetn(presetn), .bus_out(dev_out),
        .bus_in(dev_in), .wait_n(wait_n), .good_range(good_range),
        .true_level(true_level));

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : check

    task automatic hang(input string what);
        mismatches++;
        $display("BAD %0t %s timed out", $time, what);
        stop_test();
    endtask : hang

    // one apb transfer; entered and left just after a rising edge
    task automatic xfer(input logic wr, input logic [11:0] a,
        input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {20'h0, a};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            hang("bus");
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    task automatic wait_stat(input logic [2:0] want);
        int n;
        n = 0;
        do
        begin
            xfer(1'b0, `STAT_OFF, '0);
            n++;
        end
        while (d[2:0] !== want && n < 300);
        if (d[2:0] !== want)
            hang("status");
    endtask : wait_stat

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] rst [5];
        rst = '{`CTL_RST, `HPCFG_RST, `MICCFG_RST, 32'h0, 32'h0};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 5; i++)
        begin
            xfer(1'b0, 12'(i * 4), '0);
            check(d, rst[i], "reset value");
        end
        xfer(1'b1, 12'h014, 32'hFFFF_FFFF);
        check({31'h0, e}, 32'h0000_0001, "unmapped write");
        xfer(1'b0, 12'h014, '0);
        check(d, 32'h0000_0000, "unmapped read");
        check({31'h0, e}, 32'h0000_0001, "unmapped read err");
        // slow device, load needs one range step
        xfer(1'b1, `MICCFG_OFF, 32'h01FB_0213);
        xfer(1'b1, `HPCFG_OFF, 32'h0092_4030);
        xfer(1'b1, `CTL_OFF, 32'h0000_3F03);
        wait_stat(3'b010);
        check(d, 32'h0000_0012, "auto range status");
        xfer(1'b0, `RES_OFF, '0);
        check(d, 32'h0004_01F4, "result and level");
        check(dev.mem[`DEV_BIAS_IDX], 32'h0000_0001, "bias");
        check(dev.mem[`DEV_MICCTL_IDX], 32'h0000_0243, "mic ctl");
        check(dev.mem[`DEV_LVLSEL_IDX], 32'h0000_00FB, "mask");
        check(dev.mem[`DEV_DRV_IDX], 32'h0000_003B, "drivers");
        check(dev.mem[`DEV_HPD0_IDX], 32'h0000_A000, "override");
        check(dev.mem[`DEV_HPD1_IDX], 32'h0000_304B, "sense");
        check(32'(dev.polls), 32'h0000_0002, "retries");
        xfer(1'b1, `STAT_OFF, 32'h0000_0002);
        xfer(1'b0, `STAT_OFF, '0);
        check({28'h0, d[3:0]}, 32'h0000_0000, "done clear");
        xfer(1'b1, `CTL_OFF, 32'h0000_3F00);
        xfer(1'b0, `STAT_OFF, '0);
        check({28'h0, d[3:0]}, 32'h0000_0000, "zero write idle");
        check(32'(dev.polls), 32'h0000_0002, "zero write");
        // prompt device, jack sense, start queued while busy
        wait_n <= 4'h0;
        xfer(1'b1, `HPCFG_OFF, 32'h0092_4232);
        xfer(1'b1, `CTL_OFF, 32'h0000_3F01);
        xfer(1'b1, `CTL_OFF, 32'h0000_3F01);
        wait_stat(3'b010);
        check(32'(dev.polls), 32'h0000_0004, "queued start");
        check(d, 32'h0000_0002, "no retry");
        check(dev.mem[`DEV_HPD1_IDX], 32'h0000_3249, "jack");
        xfer(1'b0, `RES_OFF, '0);
        check({22'h0, d[9:0]}, 32'h0000_0064, "low code");
        // sense pin not allowed under override
        xfer(1'b1, `STAT_OFF, 32'h0000_0002);
        xfer(1'b1, `HPCFG_OFF, 32'h0092_4033);
        xfer(1'b1, `CTL_OFF, 32'h0000_3F01);
        xfer(1'b0, `STAT_OFF, '0);
        check({28'h0, d[3:0]}, 32'h0000_0008, "refused");
        xfer(1'b0, `CTL_OFF, '0);
        check(d, 32'h0000_3F00, "start reads zero");
        check(32'(dev.polls), 32'h0000_0004, "nothing sent");
        stop_test();
    end
endmodule : test_hp_det_host
